// [core/ecc_regs.svh]
// Purpose: Constants of the controller core
// Assumes: 25 MHz system clock
// Notes: Cycle counts are derived from the times
`ifndef ECC_REGS_SVH
`define ECC_REGS_SVH
`define ECC_TXF_DEPTH 48
`define ECC_RXF_DEPTH 64
`define ECC_IDX_PCS 2'h0
`define ECC_IDX_IPL 2'h1
`define ECC_IDX_IPH 2'h2
`define ECC_PCS_START 1
`define ECC_PCS_STOP 2
`define ECC_PCS_TXON 4
`define ECC_PCS_RXON 5
`define ECC_PCS_INTERRUPT_OUTPUT_ENABLE 6
`define ECC_PCS_INTR 7
`define ECC_PCS_HBERR 13
`define ECC_TD1_FCS 13
`define ECC_TD1_FIRST 9
`define ECC_TD1_LAST 8
`define ECC_SYS_NS 40
`define ECC_IFS1_NS 6000
`define ECC_IFS2_NS 3600
`define ECC_HB_NS 4000
`define ECC_BLIND_NS 500
`define ECC_IFS1_CYC ((`ECC_IFS1_NS + `ECC_SYS_NS - 1) / `ECC_SYS_NS)
`define ECC_IFS2_CYC ((`ECC_IFS2_NS + `ECC_SYS_NS - 1) / `ECC_SYS_NS)
`define ECC_HB_CYC ((`ECC_HB_NS + `ECC_SYS_NS - 1) / `ECC_SYS_NS)
`define ECC_BLIND_CYC ((`ECC_BLIND_NS - 1) / `ECC_SYS_NS)
`define ECC_CRC_INIT 32'hffffffff
`define ECC_CRC_POLY 32'hedb88320
`endif

// [core/ecc_pkg.sv]
// Purpose: Types of the controller core
// Assumes: Constants live in ecc_regs.svh
// Notes: None
package ecc_pkg;
  typedef struct packed {
    logic [15:0] word1;
    logic [15:0] word2;
  } ecc_txdesc_t;
  typedef struct packed {
    logic fcs;
    logic eof;
    logic has_data;
    logic [7:0] data;
  } ecc_txent_t;
  typedef struct packed {
    logic last;
    logic [7:0] data;
  } ecc_rxent_t;
  typedef enum logic {DESC_IDLE = 1'b0, DESC_FILL = 1'b1} ecc_desc_st_t;
  typedef enum logic [1:0] {DEF_READY = 2'b00, DEF_PART1 = 2'b01, DEF_PART2 = 2'b11} ecc_def_st_t;
  typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_SEND = 2'b01, TX_FCS = 2'b11, TX_HB = 2'b10} ecc_tx_st_t;
endpackage

// [core/ecc_core.sv]
// Purpose: Media access controller core with descriptor DMA
// Assumes: Link bytes arrive no faster than one per four link clocks
// Notes: Mode bits are plain ports; control bits sit in the PCS register
`timescale 1ns/1ns
`include "ecc_regs.svh"
module ecc_core import ecc_pkg::*; (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic link_clk,
  input wire logic slv_cs,
  input wire logic slv_write,
  input wire logic [1:0] slv_index,
  input wire logic [15:0] dal_in,
  output logic [15:0] dal_out,
  output logic dal_oe,
  output logic slv_ack,
  input wire logic suppress_tx_fcs,
  input wire logic adaptive_backoff_enable,
  input wire logic latch_strobe_polarity,
  input wire logic tx_desc_valid,
  input wire ecc_txdesc_t tx_desc,
  output logic tx_desc_ready,
  output logic tx_own_release,
  output logic tx_desc_poll,
  input wire logic [7:0] tx_dma_data,
  input wire logic tx_dma_valid,
  output logic tx_dma_ready,
  output logic [7:0] rx_dma_data,
  output logic rx_dma_last,
  output logic rx_dma_valid,
  input wire logic rx_dma_ready,
  output logic ale_out,
  output logic ale_oe,
  output logic intr_out,
  input wire logic [7:0] link_rxd,
  input wire logic link_rx_stb,
  input wire logic link_rx_last,
  input wire logic link_crs,
  input wire logic link_col,
  input wire logic link_tx_take,
  output logic [7:0] link_txd,
  output logic link_tx_en
);
  localparam logic [5:0] TXF_LAST = 6'(`ECC_TXF_DEPTH - 1);
  localparam logic [5:0] TXF_FULL = 6'(`ECC_TXF_DEPTH);
  localparam logic [6:0] RXF_FULL = 7'(`ECC_RXF_DEPTH);
  localparam logic [7:0] IFS1_LAST = 8'(`ECC_IFS1_CYC - 1);
  localparam logic [7:0] IFS2_LAST = 8'(`ECC_IFS2_CYC - 1);
  localparam logic [7:0] HB_LAST = 8'(`ECC_HB_CYC);
  localparam logic [3:0] BLIND_CYC = 4'(`ECC_BLIND_CYC);

  function automatic logic [31:0] ecc_crc8(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r >> 1) ^ ((r[0] ^ d[i]) ? `ECC_CRC_POLY : 32'h0);
    end
    return r;
  endfunction

  // ==========================================================
  // Control/status and slave access
  logic stopped_reg, stop_pend_reg, start_reg, interrupt_output_enable_reg, hberr_reg, hb_miss_reg;
  logic slv_act_reg;
  logic [15:0] ipl_reg, iph_reg, pcs_val;
  logic eng_rst;
  logic slv_start, pcs_wr, stop_wr, stop_now;

  always_comb begin
    slv_start = slv_cs && !slv_act_reg;
    pcs_wr = slv_start && slv_write && slv_index == `ECC_IDX_PCS;
    stop_wr = pcs_wr && dal_in[`ECC_PCS_STOP];
    stop_now = stop_pend_reg && !slv_cs;
    eng_rst = srst || !start_reg;
    pcs_val = 16'h0;
    pcs_val[`ECC_PCS_START] = start_reg;
    pcs_val[`ECC_PCS_STOP] = stopped_reg;
    pcs_val[`ECC_PCS_TXON] = start_reg;
    pcs_val[`ECC_PCS_RXON] = start_reg;
    pcs_val[`ECC_PCS_INTERRUPT_OUTPUT_ENABLE] = interrupt_output_enable_reg;
    pcs_val[`ECC_PCS_INTR] = hberr_reg;
    pcs_val[`ECC_PCS_HBERR] = hberr_reg;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      slv_act_reg <= 1'b0;
      slv_ack <= 1'b0;
      dal_oe <= 1'b0;
      dal_out <= 16'h0;
    end else begin
      slv_act_reg <= slv_cs;
      slv_ack <= slv_start;
      if (slv_start && !slv_write) begin
        dal_oe <= 1'b1;
        // Held for the whole access even if status moves meanwhile
        dal_out <= (slv_index == `ECC_IDX_PCS) ? pcs_val :
                   (slv_index == `ECC_IDX_IPL) ? ipl_reg :
                   (slv_index == `ECC_IDX_IPH) ? iph_reg : 16'h0;
      end else if (!slv_cs) begin
        dal_oe <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      stopped_reg <= 1'b1;
      stop_pend_reg <= 1'b0;
      start_reg <= 1'b0;
      interrupt_output_enable_reg <= 1'b0;
      hberr_reg <= 1'b0;
      intr_out <= 1'b0;
    end else begin
      if (stop_wr) begin
        stop_pend_reg <= 1'b1;
      end else if (stop_now) begin
        stop_pend_reg <= 1'b0;
      end
      if (stop_now) begin
        stopped_reg <= 1'b1;
        start_reg <= 1'b0;
      end else if (pcs_wr && !stop_wr && dal_in[`ECC_PCS_START]) begin
        stopped_reg <= 1'b0;
        start_reg <= 1'b1;
      end
      if (pcs_wr && !stop_wr) begin
        interrupt_output_enable_reg <= dal_in[`ECC_PCS_INTERRUPT_OUTPUT_ENABLE];
      end
      if (hb_miss_reg) begin
        hberr_reg <= 1'b1;
      end else if ((stop_now && !stopped_reg) || (pcs_wr && !stop_wr && dal_in[`ECC_PCS_HBERR])) begin
        hberr_reg <= 1'b0;
      end
      intr_out <= interrupt_output_enable_reg && hberr_reg;
    end
  end

  // Pointers are written only by slave writes, never by stop
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ipl_reg <= 16'h0;
      iph_reg <= 16'h0;
    end else if (slv_start && slv_write) begin
      if (slv_index == `ECC_IDX_IPL) ipl_reg <= dal_in;
      if (slv_index == `ECC_IDX_IPH) iph_reg <= dal_in;
    end
  end

  // ==========================================================
  // Link domain
  logic [1:0] ls1_reg, ls2_reg, ls3_reg, lf_reg;
  logic tx_tgl_reg, ltx_seen_reg, lpend_reg, llast_reg, lack_tgl_reg, lrx_tgl_reg, lrst_reg;
  ecc_txent_t tx_msg_reg;
  ecc_rxent_t lrx_reg;

  // Registered so no gate glitch reaches the synchroniser; a stopped core keeps the link side reset,
  // which also covers a system reset too short for the slower link clock to catch
  always_ff @(posedge sys_clk) begin
    lrst_reg <= eng_rst;
  end

  // Second and third stages must agree before a change counts
  always_ff @(posedge link_clk) begin
    ls1_reg <= {lrst_reg, tx_tgl_reg};
    ls2_reg <= ls1_reg;
    ls3_reg <= ls2_reg;
    lf_reg <= (ls2_reg & ls3_reg) | (lf_reg & (ls2_reg ^ ls3_reg));
  end

  always_ff @(posedge link_clk) begin
    if (lf_reg[1]) begin
      ltx_seen_reg <= 1'b0;
      lpend_reg <= 1'b0;
      llast_reg <= 1'b0;
      lack_tgl_reg <= 1'b0;
      link_txd <= 8'h0;
      link_tx_en <= 1'b0;
    end else if (lf_reg[0] != ltx_seen_reg) begin
      ltx_seen_reg <= lf_reg[0];
      if (tx_msg_reg.has_data) begin
        link_txd <= tx_msg_reg.data;
        link_tx_en <= 1'b1;
        lpend_reg <= 1'b1;
        llast_reg <= tx_msg_reg.eof;
      end else begin
        link_tx_en <= 1'b0;
        lack_tgl_reg <= !lack_tgl_reg;
      end
    end else if (lpend_reg && link_tx_take) begin
      lpend_reg <= 1'b0;
      lack_tgl_reg <= !lack_tgl_reg;
      if (llast_reg) link_tx_en <= 1'b0;
    end
  end

  always_ff @(posedge link_clk) begin
    if (lf_reg[1]) begin
      lrx_tgl_reg <= 1'b0;
      lrx_reg <= '0;
    end else if (link_rx_stb) begin
      lrx_reg <= {link_rx_last, link_rxd};
      lrx_tgl_reg <= !lrx_tgl_reg;
    end
  end

  // ==========================================================
  // Crossings into the system domain
  logic [3:0] ss1_reg, ss2_reg, ss3_reg, sf_reg;
  logic sack_seen_reg, srx_seen_reg, crs, col;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ss1_reg <= 4'h0;
      ss2_reg <= 4'h0;
      ss3_reg <= 4'h0;
      sf_reg <= 4'h0;
    end else begin
      ss1_reg <= {lack_tgl_reg, lrx_tgl_reg, link_crs, link_col};
      ss2_reg <= ss1_reg;
      ss3_reg <= ss2_reg;
      sf_reg <= (ss2_reg & ss3_reg) | (sf_reg & (ss2_reg ^ ss3_reg));
    end
  end
  assign crs = sf_reg[1];
  assign col = sf_reg[0];

  // ==========================================================
  // Transmit FIFO and descriptor fetch
  ecc_txent_t txf_mem [`ECC_TXF_DEPTH];
  logic [5:0] txf_wp, txf_rp, txf_cnt, txf_cnt_nx, eof_cnt;
  ecc_txent_t txf_din, txf_head;
  logic txf_push, txf_pop, desc_take, fill_end;
  ecc_desc_st_t desc_st;
  logic [15:0] buffer_byte_count_reg;
  logic dlast_reg, fcs_reg;

  always_comb begin
    desc_take = tx_desc_valid && tx_desc_ready;
    fill_end = desc_st == DESC_FILL && tx_dma_valid && tx_dma_ready && buffer_byte_count_reg == 16'hffff;
    txf_push = 1'b0;
    txf_din = '0;
    txf_din.fcs = fcs_reg;
    if (desc_take && tx_desc.word2 == 16'h0) begin
      // Empty last buffer still closes the frame
      txf_push = tx_desc.word1[`ECC_TD1_LAST];
      txf_din.eof = 1'b1;
    end else if (desc_st == DESC_FILL && tx_dma_valid && tx_dma_ready) begin
      txf_push = 1'b1;
      txf_din.eof = dlast_reg && buffer_byte_count_reg == 16'hffff;
      txf_din.has_data = 1'b1;
      txf_din.data = tx_dma_data;
    end
    txf_head = txf_mem[txf_rp];
    txf_cnt_nx = txf_cnt + {5'h0, txf_push} - {5'h0, txf_pop};
  end

  always_ff @(posedge sys_clk) begin
    if (txf_push) txf_mem[txf_wp] <= txf_din;
  end

  always_ff @(posedge sys_clk) begin
    if (eng_rst) begin
      txf_wp <= 6'h0;
      txf_rp <= 6'h0;
      txf_cnt <= 6'h0;
      eof_cnt <= 6'h0;
    end else begin
      if (txf_push) txf_wp <= (txf_wp == TXF_LAST) ? 6'h0 : txf_wp + 6'h1;
      if (txf_pop) txf_rp <= (txf_rp == TXF_LAST) ? 6'h0 : txf_rp + 6'h1;
      txf_cnt <= txf_cnt_nx;
      eof_cnt <= eof_cnt + {5'h0, txf_push && txf_din.eof} - {5'h0, txf_pop && txf_head.eof};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (eng_rst) begin
      desc_st <= DESC_IDLE;
      buffer_byte_count_reg <= 16'h0;
      dlast_reg <= 1'b0;
      fcs_reg <= 1'b1;
      tx_own_release <= 1'b0;
      tx_desc_ready <= 1'b0;
    end else begin
      tx_own_release <= (desc_take && tx_desc.word2 == 16'h0) || fill_end;
      tx_desc_ready <= desc_st == DESC_IDLE && !desc_take && txf_cnt_nx < TXF_FULL;
      if (desc_take && tx_desc.word1[`ECC_TD1_FIRST]) begin
        fcs_reg <= !suppress_tx_fcs || tx_desc.word1[`ECC_TD1_FCS];
      end
      unique case (desc_st)
        DESC_IDLE: begin
          if (desc_take && tx_desc.word2 != 16'h0) begin
            buffer_byte_count_reg <= tx_desc.word2;
            dlast_reg <= tx_desc.word1[`ECC_TD1_LAST];
            desc_st <= DESC_FILL;
          end
        end
        DESC_FILL: begin
          if (txf_push) buffer_byte_count_reg <= buffer_byte_count_reg + 16'h1;
          if (fill_end) desc_st <= DESC_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Receive FIFO, arbitration and address strobe
  ecc_rxent_t rxf_mem [`ECC_RXF_DEPTH];
  logic [5:0] rxf_wp, rxf_rp;
  logic [6:0] rxf_cnt;
  logic [3:0] blind_cnt;
  logic rx_inframe, rxf_push, rxf_pop, prio_tx_reg, grant_tx, grant_rx, master_reg;

  always_comb begin
    rxf_push = sf_reg[2] != srx_seen_reg && rxf_cnt != RXF_FULL && (rx_inframe || blind_cnt == 4'h0);
    // Alternate when both directions want the bus
    grant_tx = desc_st == DESC_FILL && (rxf_cnt == 7'h0 || prio_tx_reg);
    grant_rx = rxf_cnt != 7'h0 && !grant_tx;
    rxf_pop = grant_rx && (!rx_dma_valid || rx_dma_ready);
  end

  always_ff @(posedge sys_clk) begin
    if (rxf_push) rxf_mem[rxf_wp] <= lrx_reg;
  end

  always_ff @(posedge sys_clk) begin
    if (eng_rst) begin
      srx_seen_reg <= sf_reg[2];
      rxf_wp <= 6'h0;
      rxf_rp <= 6'h0;
      rxf_cnt <= 7'h0;
      rx_inframe <= 1'b0;
      blind_cnt <= 4'h0;
      tx_desc_poll <= 1'b0;
      rx_dma_valid <= 1'b0;
      rx_dma_data <= 8'h0;
      rx_dma_last <= 1'b0;
      prio_tx_reg <= 1'b0;
      tx_dma_ready <= 1'b0;
    end else begin
      srx_seen_reg <= sf_reg[2];
      if (rxf_push) rxf_wp <= rxf_wp + 6'h1;
      if (rxf_pop) rxf_rp <= rxf_rp + 6'h1;
      rxf_cnt <= rxf_cnt + {6'h0, rxf_push} - {6'h0, rxf_pop};
      tx_desc_poll <= rxf_push && !rx_inframe;
      if (rxf_push) rx_inframe <= !lrx_reg.last;
      if (rxf_push && lrx_reg.last) begin
        blind_cnt <= BLIND_CYC;
      end else if (blind_cnt != 4'h0) begin
        blind_cnt <= blind_cnt - 4'h1;
      end
      if (rxf_pop) begin
        rx_dma_valid <= 1'b1;
        {rx_dma_last, rx_dma_data} <= rxf_mem[rxf_rp];
      end else if (rx_dma_ready) begin
        rx_dma_valid <= 1'b0;
      end
      if (desc_st == DESC_FILL && rxf_cnt != 7'h0) prio_tx_reg <= !prio_tx_reg;
      tx_dma_ready <= grant_tx && !fill_end && txf_cnt_nx < TXF_FULL;
    end
  end

  // Strobe ends high in either polarity, so no low edge at release
  always_ff @(posedge sys_clk) begin
    if (eng_rst) begin
      master_reg <= 1'b0;
      ale_out <= 1'b1;
      ale_oe <= 1'b0;
    end else begin
      master_reg <= grant_tx || grant_rx;
      if (grant_tx || grant_rx) begin
        ale_oe <= 1'b1;
        ale_out <= latch_strobe_polarity ? 1'b0 : 1'b1;
      end else if (master_reg) begin
        ale_oe <= 1'b1;
        ale_out <= 1'b1;
      end else begin
        ale_oe <= 1'b0;
        ale_out <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Deferral
  ecc_def_st_t def_st;
  logic [7:0] def_cnt;
  logic tx_end;

  always_ff @(posedge sys_clk) begin
    if (eng_rst) begin
      def_st <= DEF_READY;
      def_cnt <= 8'h0;
    end else if (tx_end) begin
      def_st <= DEF_PART1;
      def_cnt <= 8'h0;
    end else begin
      unique case (def_st)
        DEF_READY: begin
          if (crs) def_st <= DEF_PART1;
          def_cnt <= 8'h0;
        end
        DEF_PART1: begin
          if (crs) begin
            def_cnt <= adaptive_backoff_enable ? def_cnt : 8'h0;
          end else if (def_cnt == IFS1_LAST) begin
            def_st <= DEF_PART2;
            def_cnt <= 8'h0;
          end else begin
            def_cnt <= def_cnt + 8'h1;
          end
        end
        DEF_PART2: begin
          if (def_cnt == IFS2_LAST) def_st <= DEF_READY;
          def_cnt <= def_cnt + 8'h1;
        end
      endcase
    end
  end

  // ==========================================================
  // Transmit sequencer and heartbeat
  ecc_tx_st_t tx_st;
  logic [31:0] crc_reg;
  logic [1:0] fcs_idx;
  logic [7:0] hb_cnt;
  logic col_seen, sent_any, link_busy;

  always_comb begin
    txf_pop = tx_st == TX_SEND && !link_busy && txf_cnt != 6'h0;
    tx_end = tx_st == TX_HB && !link_busy && hb_cnt == 8'h0;
  end

  always_ff @(posedge sys_clk) begin
    if (eng_rst) begin
      tx_st <= TX_IDLE;
      crc_reg <= `ECC_CRC_INIT;
      fcs_idx <= 2'h0;
      hb_cnt <= 8'h0;
      col_seen <= 1'b0;
      sent_any <= 1'b0;
      link_busy <= 1'b0;
      sack_seen_reg <= sf_reg[3];
      tx_tgl_reg <= 1'b0;
      tx_msg_reg <= '0;
      hb_miss_reg <= 1'b0;
    end else begin
      sack_seen_reg <= sf_reg[3];
      hb_miss_reg <= 1'b0;
      if (sf_reg[3] != sack_seen_reg) link_busy <= 1'b0;
      if (tx_st != TX_IDLE && col) col_seen <= 1'b1;
      unique case (tx_st)
        TX_IDLE: begin
          crc_reg <= `ECC_CRC_INIT;
          col_seen <= 1'b0;
          sent_any <= 1'b0;
          hb_cnt <= 8'h0;
          if (def_st == DEF_READY && !crs && (eof_cnt != 6'h0 || txf_cnt == TXF_FULL)) tx_st <= TX_SEND;
        end
        TX_SEND: begin
          if (txf_pop) begin
            if (txf_head.has_data || (txf_head.eof && !txf_head.fcs && sent_any)) begin
              tx_msg_reg <= txf_head;
              tx_msg_reg.eof <= txf_head.eof && !txf_head.fcs;
              tx_tgl_reg <= !tx_tgl_reg;
              link_busy <= 1'b1;
              sent_any <= 1'b1;
            end
            if (txf_head.has_data) crc_reg <= ecc_crc8(crc_reg, txf_head.data);
            if (txf_head.eof) begin
              if (!sent_any && !txf_head.has_data) tx_st <= TX_IDLE;
              else if (txf_head.fcs) tx_st <= TX_FCS;
              else tx_st <= TX_HB;
              fcs_idx <= 2'h0;
            end
          end
        end
        TX_FCS: begin
          if (!link_busy) begin
            tx_msg_reg <= '{fcs: 1'b1, eof: fcs_idx == 2'h3, has_data: 1'b1, data: ~crc_reg[8 * fcs_idx +: 8]};
            tx_tgl_reg <= !tx_tgl_reg;
            link_busy <= 1'b1;
            fcs_idx <= fcs_idx + 2'h1;
            if (fcs_idx == 2'h3) tx_st <= TX_HB;
          end
        end
        TX_HB: begin
          if (!link_busy) hb_cnt <= hb_cnt + 8'h1;
          if (hb_cnt == HB_LAST) begin
            hb_miss_reg <= !col_seen && !col;
            tx_st <= TX_IDLE;
          end
        end
      endcase
    end
  end
endmodule

// [tb/ecc_core_sva.sv]
// Purpose: Port assertions of the controller core
// Assumes: All watched ports are in the sys_clk domain
// Notes: Bound into every ecc_core
`timescale 1ns/1ns
module ecc_core_chk import ecc_pkg::*; (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic slv_cs,
  input wire logic slv_write,
  input wire logic [15:0] dal_out,
  input wire logic dal_oe,
  input wire logic slv_ack,
  input wire logic latch_strobe_polarity,
  input wire logic tx_desc_valid,
  input wire ecc_txdesc_t tx_desc,
  input wire logic tx_desc_ready,
  input wire logic tx_own_release,
  input wire logic tx_desc_poll,
  input wire logic tx_dma_ready,
  input wire logic [7:0] rx_dma_data,
  input wire logic rx_dma_valid,
  input wire logic rx_dma_ready,
  input wire logic ale_out,
  input wire logic ale_oe
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  // ========
  // Slave access
  sequence rd_start;
    $rose(slv_cs) && !slv_write;
  endsequence
  ack_pulse_a:
    assert property ($rose(slv_cs) |=> slv_ack ##1 !slv_ack) else $error("ack not a single pulse");
  rd_drive_a:
    assert property (rd_start |=> dal_oe && slv_ack) else $error("read not driven with ack");
  rd_hold_a:
    assert property (dal_oe && $past(dal_oe) |-> $stable(dal_out)) else $error("read data moved");
  rd_release_a:
    assert property (!slv_cs |=> !dal_oe) else $error("data lines kept driven");
  // ========
  // Transmit descriptors and receive DMA
  sequence zero_take;
    tx_desc_valid && tx_desc_ready && tx_desc.word2 == 16'h0;
  endsequence
  zero_desc_a:
    assert property (zero_take |=> tx_own_release) else $error("zero count not released");
  zero_nodma_a:
    assert property (zero_take |=> !tx_dma_ready [*4]) else $error("zero count started dma");
  take_drop_a:
    assert property (tx_desc_valid && tx_desc_ready |=> !tx_desc_ready) else $error("ready held after take");
  poll_pulse_a:
    assert property (tx_desc_poll |=> !tx_desc_poll) else $error("poll not a pulse");
  rx_hold_a:
    assert property (rx_dma_valid && !rx_dma_ready |=> rx_dma_valid && $stable(rx_dma_data))
      else $error("receive byte dropped");
  // ========
  // Strobe at end of mastership
  ale_high_a:
    assert property ($fell(ale_oe) && !latch_strobe_polarity |-> $past(ale_out)) else $error("strobe end low");
  ale_nolow_a:
    assert property ($fell(ale_oe) && latch_strobe_polarity |-> $past(ale_out)) else $error("strobe driven low");
endmodule
bind ecc_core ecc_core_chk chk (.sys_clk, .srst, .slv_cs, .slv_write, .dal_out, .dal_oe, .slv_ack,
  .latch_strobe_polarity, .tx_desc_valid, .tx_desc, .tx_desc_ready, .tx_own_release, .tx_desc_poll,
  .tx_dma_ready, .rx_dma_data, .rx_dma_valid, .rx_dma_ready, .ale_out, .ale_oe);

// [tb/ecc_host_mem.sv]
// Purpose: Host memory model on the far side of the DMA ports
// Assumes: One descriptor per go pulse
// Notes: Stall slows both directions at once
`timescale 1ns/1ns
module ecc_host_mem import ecc_pkg::*; (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic go,
  input wire logic [31:0] desc,
  input wire logic stall,
  input wire logic tx_desc_ready,
  output ecc_txdesc_t tx_desc,
  output logic tx_desc_valid,
  input wire logic tx_dma_ready,
  output logic [7:0] tx_dma_data,
  output logic tx_dma_valid,
  input wire logic rx_dma_valid,
  input wire logic rx_dma_last,
  output logic rx_dma_ready,
  output int served,
  output int drained,
  output int frames
);
  logic [7:0] pat;
  assign pat = 8'h10 + served[7:0];
  // Idle bus shows the inverse so a stale byte is never mistaken for data
  assign tx_dma_data = stall ? ~pat : pat;
  assign tx_dma_valid = !stall;
  // A receive buffer of real size is on offer whenever stall is low
  assign rx_dma_ready = !stall;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      tx_desc <= 32'h0;
      tx_desc_valid <= 1'b0;
    end else if (go) begin
      tx_desc <= desc;
      tx_desc_valid <= 1'b1;
    end else if (tx_desc_valid && tx_desc_ready) begin
      tx_desc <= ~tx_desc;
      tx_desc_valid <= 1'b0;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      served <= 0;
      drained <= 0;
      frames <= 0;
    end else begin
      if (tx_dma_valid && tx_dma_ready) served <= served + 1;
      if (rx_dma_valid && rx_dma_ready) begin
        drained <= drained + 1;
        frames <= frames + int'(rx_dma_last);
      end
    end
  end
endmodule

// [tb/testbench.sv]
// Purpose: Self-checking bench of the controller core
// Assumes: Host memory model serves the DMA side
// Notes: The bench plays the link adapter
`timescale 1ns/1ns
module testbench;
  logic sys_clk, link_clk, srst = 1, slv_cs = 0, slv_write = 0, go = 0, stall = 0, col_en = 1;
  logic [1:0] slv_index = 0;
  logic [15:0] dal_in = 0, rd, dal_out;
  logic [31:0] desc = 0;
  logic suppress_tx_fcs = 0, adaptive_backoff_enable = 0, latch_strobe_polarity = 0;
  logic [7:0] link_rxd = 0, tx_dma_data, rx_dma_data, link_txd, first_byte;
  logic link_rx_stb = 0, link_rx_last = 0, link_crs = 0, link_col = 0, link_tx_take = 0;
  logic dal_oe, slv_ack, tx_desc_valid, tx_desc_ready, tx_own_release, tx_desc_poll, tx_dma_valid;
  logic tx_dma_ready, rx_dma_last, rx_dma_valid, rx_dma_ready, ale_out, ale_oe, intr_out, link_tx_en;
  ecc_pkg::ecc_txdesc_t tx_desc;
  int err_total = 0, checked = 0, nbytes = 0, gap = 0, polls = 0, served, drained, frames;
  ecc_core dut (.sys_clk, .srst, .link_clk, .slv_cs, .slv_write, .slv_index, .dal_in, .dal_out, .dal_oe,
    .slv_ack, .suppress_tx_fcs, .adaptive_backoff_enable, .latch_strobe_polarity, .tx_desc_valid,
    .tx_desc, .tx_desc_ready, .tx_own_release, .tx_desc_poll, .tx_dma_data, .tx_dma_valid,
    .tx_dma_ready, .rx_dma_data, .rx_dma_last, .rx_dma_valid, .rx_dma_ready, .ale_out, .ale_oe,
    .intr_out, .link_rxd, .link_rx_stb, .link_rx_last, .link_crs, .link_col, .link_tx_take,
    .link_txd, .link_tx_en);
  ecc_host_mem mem (.sys_clk, .srst, .go, .desc, .stall, .tx_desc_ready, .tx_desc, .tx_desc_valid,
    .tx_dma_ready, .tx_dma_data, .tx_dma_valid, .rx_dma_valid, .rx_dma_last, .rx_dma_ready,
    .served, .drained, .frames);
  // ========
  // Clocks, link adapter and monitors
  initial begin
    sys_clk = 0;
    forever #20 sys_clk = ~sys_clk;
  end
  initial begin
    link_clk = 0;
    #7;
    forever #40 link_clk = ~link_clk;
  end
  // Serialiser pace: one byte every ten link clocks; enable stays high between bytes,
  // so a pace faster than the core's byte turnaround would take a byte not yet presented
  always @(posedge link_clk) begin
    link_tx_take <= 1'b0;
    link_col <= link_tx_en && col_en;
    gap = (gap > 0) ? gap - 1 : 0;
    if (link_tx_en === 1'b1 && gap == 0) begin
      link_tx_take <= 1'b1;
      gap = 10;
      if (nbytes == 0) first_byte = link_txd;
      nbytes++;
    end
  end
  always @(posedge sys_clk) polls += int'(tx_desc_poll === 1'b1);
  // ========
  // Tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic acc(input logic wr, input logic [1:0] ix, input logic [15:0] d);
    @(posedge sys_clk);
    slv_cs <= 1'b1;
    slv_write <= wr;
    slv_index <= ix;
    dal_in <= d;
    @(posedge sys_clk);
    for (int i = 0; i < 4 && slv_ack !== 1'b1; i++) @(posedge sys_clk);
    rd = dal_out;
    slv_cs <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rdchk(input logic [1:0] ix, input logic [15:0] m, input logic [15:0] exp);
    acc(1'b0, ix, 16'h0);
    check(rd & m, exp);
  endtask
  // Settle span covers carrier, deferral of 240, twenty bytes and the heartbeat window of 100
  task automatic send(input logic [15:0] w1, input logic [15:0] w2, input logic [15:0] nexp);
    int base;
    base = served;
    first_byte = 8'hff;
    nbytes = 0;
    desc <= {w1, w2};
    go <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    for (int i = 0; i < 2000 && tx_own_release !== 1'b1; i++) @(posedge sys_clk);
    check({15'h0, tx_own_release}, 16'h1);
    repeat (1000) @(posedge sys_clk);
    check(nbytes[15:0], nexp);
    check({8'h0, first_byte}, (nexp == 16'h0) ? 16'h00ff : 16'h0010 + base[15:0]);
  endtask
  task automatic rx_frame(input int n);
    link_crs <= 1'b1;
    for (int i = 0; i < n; i++) begin
      @(posedge link_clk);
      link_rx_stb <= 1'b1;
      link_rxd <= 8'h40 + i[7:0];
      link_rx_last <= (i == n - 1);
      @(posedge link_clk);
      link_rx_stb <= 1'b0;
      link_rxd <= ~link_rxd;
      repeat (3) @(posedge link_clk);
    end
    link_crs <= 1'b0;
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ========
  // Tests
  initial begin
    #(40 * 40000);
    err_total++;
    give_verdict();
  end
  initial begin
    repeat (4) @(posedge sys_clk);
    srst <= 1'b0;
    rdchk(0, 16'hffff, 16'h0004);
    acc(1, 1, 16'h1234);
    acc(1, 2, 16'h00ab);
    acc(1, 3, 16'hbeef);
    rdchk(3, 16'hffff, 16'h0000);
    acc(1, 0, 16'h0040);
    rdchk(0, 16'hffff, 16'h0044);
    acc(1, 0, 16'h0004);
    rdchk(0, 16'hffff, 16'h0044);
    acc(1, 0, 16'h0042);
    rdchk(0, 16'h0046, 16'h0042);
    for (int k = 0; k < 4; k++) begin
      suppress_tx_fcs <= k[0] ^ k[1];
      latch_strobe_polarity <= k[0];
      send(16'h0300 | {2'h0, k[1], 13'h0}, 16'hfffd, ((k[0] ^ k[1]) && !k[1]) ? 16'd3 : 16'd7);
    end
    rdchk(0, 16'h2000, 16'h0000);
    check({15'h0, intr_out}, 16'h0);
    send(16'h0300, 16'h0000, 16'd0);
    col_en <= 1'b0;
    send(16'h0300, 16'hffff, 16'd5);
    rdchk(0, 16'h2000, 16'h2000);
    check({15'h0, intr_out}, 16'h1);
    col_en <= 1'b1;
    acc(1, 0, 16'h2040);
    rdchk(0, 16'h2000, 16'h0000);
    adaptive_backoff_enable <= 1'b1;
    fork
      rx_frame(20);
      send(16'h0300, 16'hfff0, 16'd20);
      repeat (40) begin
        repeat (3) @(posedge sys_clk);
        stall <= ~stall;
      end
    join
    check(polls[15:0], 16'd1);
    check(drained[15:0], 16'd20);
    rx_frame(4);
    repeat (2) @(posedge link_clk);
    rx_frame(4);
    repeat (200) @(posedge sys_clk);
    check(frames[15:0], 16'd3);
    acc(1, 0, 16'h0004);
    rdchk(0, 16'h0006, 16'h0004);
    check({15'h0, tx_desc_ready}, 16'h0);
    rdchk(1, 16'hffff, 16'h1234);
    rdchk(2, 16'h00ff, 16'h00ab);
    give_verdict();
  end
endmodule
